// ---- rpc_pkg.sv ----
// Package of constants and types for the reading phase controller
// Behaviour
// [R1] Triggered mode: decode only between window-open and window-close events.
// [R2] Window events come from sensor inputs or host serial start/stop strings.
// [R3] Operating mode is triggered, continuous or package tracking.
// [R4] Triggered sub-options: one input, two inputs, or serial strings.
// [R5] Single-input: window equals active phase of the start input.
// [R6] Good decode: send code, raise good-read event at window end.
// [R7] No decode: send no-read message and no-read event at window end.
// [R8] A selector picks which numbered physical input starts the cycle.
// [R9] Open-active polarity: input active while no current flows.
// [R10] Closed-active polarity: input active while current flows.
// [R11] Timeout allowed only in serial and single-input sub-options.
// [R12] Timeout programmable from 40 to 15000 ms.
// [R13] Timeout origin selector; counting from start event is normal.
// [R14] Counting from stop: window stays open timeout after stop event.
// [R15] Two-input: open on start active, close on stop inactive.
// [R16] Extended phase: stop closes window only if start also inactive.
// [R17] Inputs synchronised before polarity; timer runs on a 1 ms tick.
// [R18] Timeout expiry closes the window and reports as a close event.
`default_nettype none
package rpc_pkg;
  localparam int unsigned CLK_HZ      = 100_000_000;
  localparam int unsigned TICK_MS     = 1;
  localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam logic [13:0] TMO_MIN_MS  = 14'h0028;
  localparam logic [13:0] TMO_MAX_MS  = 14'h3A98;
  localparam logic [13:0] TMO_RST_MS  = 14'h01F4;
  localparam int unsigned NUM_INPUTS  = 4;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_INSEL  = 12'h004;
  localparam logic [11:0] ADDR_TMO    = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_EVENT  = 12'h010;

  // CTRL field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_SUB_LSB  = 2;
  localparam int unsigned CTRL_TMO_EN   = 4;
  localparam int unsigned CTRL_TMO_STOP = 5;
  localparam int unsigned CTRL_EXT      = 6;
  localparam int unsigned CTRL_SPOL     = 7;
  localparam int unsigned CTRL_PPOL     = 8;
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] INSEL_RST     = 32'h0000_0100;

  typedef enum logic [1:0] {
    RPC_TRIGGERED             = 2'h0,
    RPC_CONTINUOUS            = 2'h1,
    RPC_PACKAGE_TRACKING_MODE = 2'h2
  } rpc_mode_e;

  typedef enum logic [1:0] {
    RPC_ONE_INPUT = 2'h0,
    RPC_TWO_INPUT = 2'h1,
    RPC_SERIAL    = 2'h2
  } rpc_sub_e;

  typedef enum logic [2:0] {
    RPC_IDLE = 3'b001,
    RPC_OPEN = 3'b010,
    RPC_HOLD = 3'b100
  } rpc_state_e;

  typedef struct packed {
    logic open_active;
    logic good;
    logic noread;
  } rpc_result_s;
endpackage
`default_nettype wire

// ---- rpc_reading_phase.sv ----
// Reading phase controller with APB registers
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none
module rpc_reading_phase #(
  parameter int unsigned TICK_CYC = rpc_pkg::TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  sensor_in,
  input  wire logic        serial_start,
  input  wire logic        serial_stop,
  input  wire logic        decode_ok,
  output logic             window_open,
  output logic             good_read,
  output logic             no_read
);
  logic [31:0] ctrl_ff, insel_ff, nxt_ctrl, nxt_insel;
  logic [13:0] tmo_ff, nxt_tmo;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pslverr_ff, pready_ff;
  logic [3:0]  sync1_ff, sync2_ff;
  logic        stop_act_ff;
  logic [31:0] tick_cnt_ff;
  logic        tick_ff;
  logic [13:0] ms_cnt_ff;
  logic        decoded_ff, good_ff, noread_ff, win_ff;
  logic [1:0]  ev_cnt_good_ff, ev_cnt_no_ff;
  rpc_pkg::rpc_state_e state_ff, nxt_state;

  // APB decode
  wire access  = psel && penable;
  wire wr      = access && pwrite;
  wire hit_c   = paddr == rpc_pkg::ADDR_CTRL;
  wire hit_i   = paddr == rpc_pkg::ADDR_INSEL;
  wire hit_t   = paddr == rpc_pkg::ADDR_TMO;
  wire hit_s   = paddr == rpc_pkg::ADDR_STATUS;
  wire hit_e   = paddr == rpc_pkg::ADDR_EVENT;
  wire mapped  = hit_c | hit_i | hit_t | hit_s | hit_e;
  // Out-of-range timeout writes are clamped into 40..15000 ms
  // Whole word compared so large values clamp instead of wrapping
  wire [31:0] wtmo = pwdata;
  wire [13:0] clamp_tmo = (wtmo < {18'h0, rpc_pkg::TMO_MIN_MS}) ?
                          rpc_pkg::TMO_MIN_MS :
                          (wtmo > {18'h0, rpc_pkg::TMO_MAX_MS}) ?
                          rpc_pkg::TMO_MAX_MS : wtmo[13:0];  // [R12]

  assign nxt_ctrl  = (wr && hit_c) ? {23'h0, pwdata[8:0]} : ctrl_ff;
  assign nxt_insel = (wr && hit_i) ?
                     {22'h0, pwdata[9:8], 6'h0, pwdata[1:0]} : insel_ff;
  assign nxt_tmo   = (wr && hit_t) ? clamp_tmo : tmo_ff;

  wire rpc_pkg::rpc_mode_e mode =
    rpc_pkg::rpc_mode_e'(ctrl_ff[rpc_pkg::CTRL_MODE_LSB +: 2]);   // [R3]
  wire rpc_pkg::rpc_sub_e sub =
    rpc_pkg::rpc_sub_e'(ctrl_ff[rpc_pkg::CTRL_SUB_LSB +: 2]);     // [R4]
  wire tmo_stop = ctrl_ff[rpc_pkg::CTRL_TMO_STOP];
  wire ext_ph   = ctrl_ff[rpc_pkg::CTRL_EXT];
  wire [1:0] start_sel = insel_ff[1:0];                          // [R8]
  wire [1:0] stop_sel  = insel_ff[9:8];

  wire [31:0] status_word = {26'h0, state_ff, decoded_ff, win_ff, 1'b0};
  wire [31:0] event_word  = {28'h0, ev_cnt_no_ff, ev_cnt_good_ff};
  assign nxt_prdata = hit_c ? ctrl_ff :
                      hit_i ? insel_ff :
                      hit_t ? {18'h0, tmo_ff} :
                      hit_s ? status_word :
                      hit_e ? event_word : 32'h0000_0000;

  // Polarity after sync: raw high means current flows
  wire start_raw = sync2_ff[start_sel];
  wire stop_raw  = sync2_ff[stop_sel];
  wire start_act = ctrl_ff[rpc_pkg::CTRL_SPOL] ? start_raw    // [R10]
                                               : ~start_raw;  // [R9]
  wire stop_act  = ctrl_ff[rpc_pkg::CTRL_PPOL] ? stop_raw : ~stop_raw;
  // Falling edge only: an idle stop sensor must not end a fresh window
  wire stop_fall = stop_act_ff && !stop_act;                    // [R15]

  wire trig_mode = mode == rpc_pkg::RPC_TRIGGERED;
  wire tmo_ok    = ctrl_ff[rpc_pkg::CTRL_TMO_EN] &&
                   (sub == rpc_pkg::RPC_ONE_INPUT ||
                    sub == rpc_pkg::RPC_SERIAL);               // [R11]
  // Open and close events per sub-option
  wire open_ev  = trig_mode &&
                  ((sub == rpc_pkg::RPC_SERIAL) ? serial_start :
                   start_act);                                  // [R2] [R15]
  wire close_ev = (sub == rpc_pkg::RPC_SERIAL)    ? serial_stop :
                  (sub == rpc_pkg::RPC_ONE_INPUT) ? ~start_act :  // [R5]
                  (ext_ph ? (~stop_act && ~start_act)           // [R16]
                          : stop_fall);                         // [R15]
  wire tmo_hit  = tmo_ok && tick_ff && (ms_cnt_ff + 14'h0001 >= tmo_ff);
  wire ms_from_start = tmo_ok && !tmo_stop && state_ff == rpc_pkg::RPC_OPEN;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rpc_pkg::RPC_IDLE: if (open_ev) nxt_state = rpc_pkg::RPC_OPEN;
      rpc_pkg::RPC_OPEN: begin
        if (!trig_mode) nxt_state = rpc_pkg::RPC_IDLE;
        else if (ms_from_start && tmo_hit)
          nxt_state = rpc_pkg::RPC_IDLE;                        // [R18]
        else if (close_ev)
          nxt_state = (tmo_ok && tmo_stop) ? rpc_pkg::RPC_HOLD  // [R14]
                                           : rpc_pkg::RPC_IDLE; // [R1]
      end
      rpc_pkg::RPC_HOLD: if (tmo_hit || !trig_mode)
        nxt_state = rpc_pkg::RPC_IDLE;                          // [R14]
      default: nxt_state = rpc_pkg::RPC_IDLE;
    endcase
  end

  wire closing = state_ff != rpc_pkg::RPC_IDLE &&
                 nxt_state == rpc_pkg::RPC_IDLE;
  // Continuous and tracking modes acquire freely
  wire nxt_win = (nxt_state != rpc_pkg::RPC_IDLE) || !trig_mode;
  wire restart = (state_ff == rpc_pkg::RPC_IDLE) ||
                 (state_ff == rpc_pkg::RPC_OPEN &&
                  nxt_state == rpc_pkg::RPC_HOLD);              // [R13]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= rpc_pkg::CTRL_RST;
      insel_ff   <= rpc_pkg::INSEL_RST;
      tmo_ff     <= rpc_pkg::TMO_RST_MS;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      ctrl_ff    <= nxt_ctrl;
      insel_ff   <= nxt_insel;
      tmo_ff     <= nxt_tmo;
      prdata_ff  <= (psel && !penable && !pwrite) ? nxt_prdata : prdata_ff;
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff    <= 4'h0;
      sync2_ff    <= 4'h0;
      stop_act_ff <= 1'b0;
    end else begin
      sync1_ff    <= sensor_in;                                 // [R17]
      sync2_ff    <= sync1_ff;
      stop_act_ff <= stop_act;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 32'h0000_0000;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= tick_cnt_ff == TICK_CYC - 1;               // [R17]
      tick_cnt_ff <= (tick_cnt_ff == TICK_CYC - 1) ? 32'h0000_0000
                                                   : tick_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff   <= rpc_pkg::RPC_IDLE;
      ms_cnt_ff  <= 14'h0000;
      decoded_ff <= 1'b0;
      win_ff     <= 1'b0;
      good_ff    <= 1'b0;
      noread_ff  <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      win_ff    <= nxt_win;                                     // [R1]
      ms_cnt_ff <= restart ? 14'h0000 :
                   tick_ff ? ms_cnt_ff + 14'h0001 : ms_cnt_ff;  // [R12]
      // Decode is only counted while the window is open
      decoded_ff <= (state_ff == rpc_pkg::RPC_IDLE) ? 1'b0 :
                    (decoded_ff | (decode_ok & win_ff));        // [R1]
      good_ff   <= closing && (decoded_ff | (decode_ok & win_ff)); // [R6]
      noread_ff <= closing && !(decoded_ff | (decode_ok & win_ff)); // [R7]
    end
  end

  // Saturating event counters for software visibility
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_cnt_good_ff <= 2'h0;
      ev_cnt_no_ff   <= 2'h0;
    end else begin
      ev_cnt_good_ff <= (good_ff && ev_cnt_good_ff != 2'h3) ?
                        ev_cnt_good_ff + 2'h1 : ev_cnt_good_ff;
      ev_cnt_no_ff   <= (noread_ff && ev_cnt_no_ff != 2'h3) ?
                        ev_cnt_no_ff + 2'h1 : ev_cnt_no_ff;
    end
  end

  assign prdata      = prdata_ff;
  assign pready      = pready_ff;
  assign pslverr     = pslverr_ff;
  assign window_open = win_ff;
  assign good_read   = good_ff;
  assign no_read     = noread_ff;

  result_excl_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(good_read && no_read))
    else $error("good and no read together");                  // [R6]
  result_at_close_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (good_read || no_read) |-> trig_mode && $past(closing))
    else $error("result without window close");                 // [R7]
  win_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    (trig_mode && state_ff == rpc_pkg::RPC_IDLE &&
     $past(state_ff) == rpc_pkg::RPC_IDLE) |-> !window_open)
    else $error("window open outside phase");                   // [R1]
  one_in_close_a: assert property (@(posedge pclk)
    disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_OPEN && sub == rpc_pkg::RPC_ONE_INPUT &&
     !tmo_ok && trig_mode && !start_act) |=> state_ff == rpc_pkg::RPC_IDLE)
    else $error("single input window not closed");             // [R5]
  ext_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_OPEN && sub == rpc_pkg::RPC_TWO_INPUT &&
     ext_ph && start_act && trig_mode) |=> state_ff == rpc_pkg::RPC_OPEN)
    else $error("extended phase closed early");                 // [R16]
  two_close_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_OPEN && sub == rpc_pkg::RPC_TWO_INPUT &&
     !ext_ph && stop_fall && trig_mode) |=> state_ff == rpc_pkg::RPC_IDLE)
    else $error("two input stop ignored");                      // [R15]
  tmo_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    tmo_ff >= rpc_pkg::TMO_MIN_MS && tmo_ff <= rpc_pkg::TMO_MAX_MS)
    else $error("timeout out of range");                        // [R12]
  no_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_HOLD) |-> tmo_ok && tmo_stop)
    else $error("hold without stop timeout");                   // [R11]
  hold_end_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_HOLD && tmo_hit) |=> !window_open || !trig_mode)
    else $error("hold timeout did not close");                  // [R14]
  open_serial_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_ff == rpc_pkg::RPC_IDLE && trig_mode &&
     sub == rpc_pkg::RPC_SERIAL && serial_start) |=> window_open)
    else $error("serial start did not open");                   // [R2]
endmodule
`default_nettype wire

// ---- rpc_host_model.sv ----
// Behavioural presence sensors and serial host for the trigger inputs
`default_nettype none
module rpc_host_model (
  input  wire logic       pclk,
  output logic      [3:0] sensor_in,
  output logic            serial_start,
  output logic            serial_stop
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sensor_in    = 4'h0;
    serial_start = 1'b0;
    serial_stop  = 1'b0;
  end
  // Contact level, high while current flows; held until changed
  task automatic set_in(input int idx, input logic lvl);
    @(posedge pclk);
    sensor_in[idx] <= lvl;
  endtask
  // Start or stop string arrives as a one-cycle strobe
  task automatic ser(input logic stop);
    @(posedge pclk);
    serial_start <= ~stop;
    serial_stop  <= stop;
    @(posedge pclk);
    serial_start <= 1'b0;
    serial_stop  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- rpc_reading_phase_tb.sv ----
// Self-checking bench for the reading phase controller
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module rpc_reading_phase_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TCK = 10;
  logic        pclk, presetn, psel, penable, pwrite, decode_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, window_open, good_read, no_read;
  logic [3:0]  sensor_in;
  logic        serial_start, serial_stop;
  int          n_errors, cmp_count, n_good, n_nr, g0, r0, n;
  rpc_reading_phase #(.TICK_CYC(10)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sensor_in(sensor_in), .serial_start(serial_start),
    .serial_stop(serial_stop), .decode_ok(decode_ok),
    .window_open(window_open), .good_read(good_read), .no_read(no_read));
  rpc_host_model u_host (.pclk(pclk), .sensor_in(sensor_in),
    .serial_start(serial_start), .serial_stop(serial_stop));
  initial begin
    pclk = 1'b0;
    forever #(TCK / 2) pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (good_read === 1'b1) n_good++;
    if (no_read === 1'b1) n_nr++;
  end
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Master holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_win(input logic v);
    int k;
    k = 0;
    while (window_open !== v && k < 60) begin
      @(posedge pclk);
      k++;
    end
    `CHK(window_open, v)
  endtask
  task automatic dec();
    @(posedge pclk);
    decode_ok <= 1'b1;
    @(posedge pclk);
    decode_ok <= 1'b0;
  endtask
  task automatic snap();
    g0 = n_good;
    r0 = n_nr;
  endtask
  task automatic t_regs();
    apb(0, 12'h000, 0); `CHK(rd, 32'h0000_0000)
    apb(0, 12'h004, 0); `CHK(rd, 32'h0000_0100)
    apb(0, 12'h008, 0); `CHK(rd[13:0], 14'h01F4)
    apb(0, 12'h020, 0); `CHK(err, 1'b1)
    apb(1, 12'h008, 32'h0000_000A);
    apb(0, 12'h008, 0); `CHK(rd[13:0], 14'h0028)
    apb(1, 12'h008, 32'h0000_4E20);
    apb(0, 12'h008, 0); `CHK(rd[13:0], 14'h3A98)
  endtask
  task automatic t_single();
    wait_win(1'b1);
    snap();
    u_host.set_in(0, 1'b1);
    wait_win(1'b0);
    repeat (4) @(posedge pclk);
    `CHK(n_nr - r0, 1)
    u_host.set_in(0, 1'b0);
    apb(1, 12'h000, 32'h0000_0080);
    wait_win(1'b0);
    dec();
    repeat (4) @(posedge pclk);
    snap();
    u_host.set_in(0, 1'b1);
    wait_win(1'b1);
    u_host.set_in(0, 1'b0);
    wait_win(1'b0);
    repeat (4) @(posedge pclk);
    `CHK(n_nr - r0, 1)
    `CHK(n_good - g0, 0)
    u_host.set_in(0, 1'b1);
    wait_win(1'b1);
    dec();
    u_host.set_in(0, 1'b0);
    wait_win(1'b0);
    repeat (4) @(posedge pclk);
    `CHK(n_good - g0, 1)
  endtask
  task automatic t_insel();
    apb(1, 12'h004, 32'h0000_0102);
    u_host.set_in(0, 1'b1);
    repeat (10) @(posedge pclk);
    `CHK(window_open, 1'b0)
    u_host.set_in(2, 1'b1);
    wait_win(1'b1);
    u_host.set_in(2, 1'b0);
    u_host.set_in(0, 1'b0);
    wait_win(1'b0);
    apb(1, 12'h004, 32'h0000_0100);
  endtask
  task automatic t_two(input logic [31:0] c);
    apb(1, 12'h000, c);
    u_host.set_in(0, 1'b1);
    wait_win(1'b1);
    if (c[6]) u_host.set_in(1, 1'b1);
    else u_host.set_in(0, 1'b0);
    u_host.set_in(1, 1'b1);
    u_host.set_in(1, 1'b0);
    repeat (10) @(posedge pclk);
    `CHK(window_open, c[6])
    u_host.set_in(0, 1'b0);
    wait_win(1'b0);
  endtask
  task automatic t_serial();
    apb(1, 12'h000, 32'h0000_0008);
    u_host.ser(1'b0);
    wait_win(1'b1);
    snap();
    dec();
    u_host.ser(1'b1);
    wait_win(1'b0);
    repeat (4) @(posedge pclk);
    `CHK(n_good - g0, 1)
    apb(0, 12'h010, 0);
    `CHK(rd[3:0], 4'hE)
  endtask
  task automatic t_tmo(input logic from_stop);
    apb(1, 12'h008, 32'h0000_0028);
    apb(1, 12'h000, from_stop ? 32'h0000_00B0 : 32'h0000_0090);
    u_host.set_in(0, 1'b1);
    wait_win(1'b1);
    snap();
    if (from_stop) u_host.set_in(0, 1'b0);
    n = 0;
    while (window_open === 1'b1 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    `CHK(n >= 370 && n <= 440, 1'b1)
    repeat (4) @(posedge pclk);
    `CHK(n_nr - r0, 1)
    u_host.set_in(0, 1'b0);
  endtask
  initial begin
    presetn   = 1'b0;
    {psel, penable, pwrite, decode_ok} = 4'h0;
    paddr     = 12'h000;
    pwdata    = 32'h0000_0000;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_single();
    t_insel();
    t_two(32'h0000_0184);
    t_two(32'h0000_01C4);
    t_serial();
    t_tmo(1'b0);
    t_tmo(1'b1);
    for (int m = 1; m < 3; m++) begin
      apb(1, 12'h000, m);
      wait_win(1'b1);
    end
    stop_test();
  end
  initial begin
    #(TCK * 20000);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
